// ---- rtl/can_mbm_consts.svh ----
// Offsets, field positions, reset values and sizes of the message buffer manager
`ifndef CAN_MBM_CONSTS_SVH
`define CAN_MBM_CONSTS_SVH
`define MBM_TX_BUFS        3
`define MBM_TX_BYTES       16
`define MBM_TX_MSG_BYTES   13
`define MBM_LOCAL_PRIORITY_BYTE      4'hd
`define MBM_TS_HI_BYTE     4'he
`define MBM_TS_LO_BYTE     4'hf
`define MBM_RX_SLOTS       5
`define MBM_RX_BYTES       15
`define MBM_RX_TS_HI       4'hd
`define MBM_RX_TS_LO       4'he
`define MBM_ADDR_TX_FLAG   8'h00
`define MBM_ADDR_TX_SEL    8'h01
`define MBM_ADDR_ABT_REQ   8'h02
`define MBM_ADDR_ABT_ACK   8'h03
`define MBM_ADDR_RX_FLAG   8'h04
`define MBM_ADDR_CTRL      8'h05
`define MBM_ADDR_IRQ_EN    8'h06
`define MBM_ADDR_TX_WIN    4'h1
`define MBM_ADDR_RX_WIN    4'h2
`define MBM_CTRL_INIT      0
`define MBM_CTRL_LOOP      1
`define MBM_CTRL_TSEN      2
`define MBM_RXF_FULL       0
`define MBM_RXF_OVR        1
`define MBM_IRQ_RX         3
`define MBM_IRQ_OVR        4
`define MBM_CTRL_RESET     8'h01
`define MBM_TXE_RESET      3'h7
`endif

// ---- rtl/can_mbm_pkg.sv ----
// Types shared by the message buffer manager
package can_mbm_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BUSY = 2'b10
  } tx_state_type;
endpackage : can_mbm_pkg

// ---- rtl/can_message_buffer_manager.sv ----
// Transmit buffers, priority scheduler, abort logic and receive FIFO of a CAN controller
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "can_mbm_consts.svh"
// What this block does
// - Three independent transmit buffers allow back-to-back queued frames.
// - Each transmit buffer holds 13 message bytes, priority byte, two stamp bytes.
// - Software selects an empty buffer; it appears in the shared transmit window.
// - Clearing a buffer's empty flag marks it ready for transmission.
// - Successful send sets the empty flag; set empty flags raise unmasked transmit interrupt.
// - Among pending buffers the numerically lowest local priority goes first.
// - Priority selection reruns at every arbitration, also after a transmission error.
// - Abort of pending, not-sending buffer sets acknowledge, empty flag, transmit interrupt.
// - Acknowledge stays 1 after an abort and 0 after a real send.
// - Five-slot receive FIFO; background slot device-owned, foreground slot software-readable.
// - Each receive slot holds 15 bytes: control, identifier, data, time stamp.
// - Receive-full flag is set while foreground holds a valid accepted frame.
// - Incoming frame bytes go into the background slot while filtering runs.
// - Valid accepted frame shifts into FIFO; flag set and unmasked receive interrupt.
// - A following frame lands in the next free background slot.
// - Invalid or rejected frames are not shifted; next frame overwrites them.
// - Own frames outside loopback are captured but never queued, interrupted or acknowledged.
// - In loopback own frames are treated like any received frame.
// - After lost arbitration the block immediately receives the winning frame.
// - Valid accepted frame with FIFO full is dropped and raises overrun interrupt if enabled.
// - Transmission continues while full; acceptance resumes once a slot frees.
// - With stamping enabled, the bit timer is written into the buffer at frame end.
// - Stamp timer is zero in initialization mode and has no overflow indication.
module can_message_buffer_manager (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       bit_tick,
  input  wire logic       arb_start,
  input  wire logic       tx_done,
  input  wire logic       tx_error,
  input  wire logic       arb_lost,
  input  wire logic [3:0] tx_rd_idx,
  output logic            tx_pending,
  output logic      [1:0] tx_cur_buf,
  output logic      [7:0] tx_rd_data,
  input  wire logic       rx_wr,
  input  wire logic [3:0] rx_wr_idx,
  input  wire logic [7:0] rx_wr_data,
  input  wire logic       rx_end,
  input  wire logic       rx_valid,
  input  wire logic       rx_accept,
  input  wire logic       rx_own,
  output logic            rx_ack_ok,
  output logic            tx_irq,
  output logic            rx_irq,
  output logic            err_irq
);

  //////////////////////////////////////////////////////////////////////////////////////
  // State and storage
  logic [7:0]                tx_mem [`MBM_TX_BUFS][`MBM_TX_BYTES];
  logic [7:0]                rx_mem [`MBM_RX_SLOTS][`MBM_RX_BYTES];
  logic [2:0]                txe_q, txe_d;
  logic [2:0]                abt_req_q, abt_req_d;
  logic [2:0]                abt_ack_q, abt_ack_d;
  logic [2:0]                sel_q;
  logic [1:0]                cur_q;
  can_mbm_pkg::tx_state_type tx_state_q;
  logic [2:0]                head_q;
  logic [2:0]                count_q, count_d;
  logic                      ovr_q;
  logic [7:0]                ctrl_q;
  logic [4:0]                irq_en_q;
  logic [15:0]               timer_q;
  logic [7:0]                tx_rd_data_q;

  //////////////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Slot index arithmetic modulo five
  function automatic logic [2:0] slot_add(input logic [2:0] a, input logic [2:0] b);
    logic [3:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 4'd5) begin
      s = s - 4'd5;
    end
    return s[2:0];
  endfunction : slot_add

  // Index of the lowest set bit of a three-bit mask
  function automatic logic [1:0] low_index(input logic [2:0] m);
    logic [1:0] r;
    r = 2'd0;
    if (m[0]) begin
      r = 2'd0;
    end else if (m[1]) begin
      r = 2'd1;
    end else if (m[2]) begin
      r = 2'd2;
    end
    return r;
  endfunction : low_index

  //////////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire       init_mode  = ctrl_q[`MBM_CTRL_INIT];
  wire       loopback   = ctrl_q[`MBM_CTRL_LOOP];
  wire       ts_en      = ctrl_q[`MBM_CTRL_TSEN];
  wire       wr_txflag  = reg_wr && (reg_addr == `MBM_ADDR_TX_FLAG);
  wire       wr_txsel   = reg_wr && (reg_addr == `MBM_ADDR_TX_SEL);
  wire       wr_abtreq  = reg_wr && (reg_addr == `MBM_ADDR_ABT_REQ);
  wire       wr_rxflag  = reg_wr && (reg_addr == `MBM_ADDR_RX_FLAG);
  wire       wr_ctrl    = reg_wr && (reg_addr == `MBM_ADDR_CTRL);
  wire       wr_irqen   = reg_wr && (reg_addr == `MBM_ADDR_IRQ_EN);
  wire       in_txwin   = (reg_addr[7:4] == `MBM_ADDR_TX_WIN);
  wire       in_rxwin   = (reg_addr[7:4] == `MBM_ADDR_RX_WIN);
  wire [1:0] sel_idx    = low_index(sel_q);
  wire       sel_ok     = (sel_q != 3'b000) && ((sel_q & txe_q) != 3'b000);
  // Only empty buffers may be picked; the lowest such bit is kept one-hot
  wire [2:0] sel_pick   = reg_wdata[2:0] & txe_q;
  // Stamp bytes are read only; a queued buffer is locked against writes
  wire       win_wr     = reg_wr && in_txwin && sel_ok
                          && (reg_addr[3:0] < `MBM_TS_HI_BYTE);
  wire       sending    = (tx_state_q == can_mbm_pkg::TX_BUSY);
  wire [2:0] bg_slot    = slot_add(head_q, count_q);
  wire       fifo_full  = (count_q == 3'(`MBM_RX_SLOTS));
  wire       own_drop   = rx_own && !loopback;
  wire       rx_good    = rx_end && rx_valid && rx_accept && !own_drop;
  wire       rx_shift   = rx_good && !fifo_full;
  wire       rx_ovr     = rx_good && fifo_full;
  wire       rx_release = wr_rxflag && reg_wdata[`MBM_RXF_FULL] && (count_q != 3'd0);
  wire       rx_full    = (count_q != 3'd0);
  wire [2:0] pending    = ~txe_q;

  // Pick the pending buffer with the lowest priority byte; ties go to the lower index
  logic [1:0] best;
  logic [7:0] best_local_priority;
  logic       best_any;
  always_comb begin
    best      = 2'd0;
    best_local_priority = 8'hff;
    best_any  = 1'b0;
    for (int b = 0; b < `MBM_TX_BUFS; b++) begin
      if (pending[b] && !abt_req_q[b]
          && (!best_any || tx_mem[b][`MBM_LOCAL_PRIORITY_BYTE] < best_local_priority)) begin
        best      = 2'(b);
        best_local_priority = tx_mem[b][`MBM_LOCAL_PRIORITY_BYTE];
        best_any  = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Transmit flags: hardware sets win over software clears
  generate
    for (genvar g = 0; g < `MBM_TX_BUFS; g++) begin : g_txflags
      wire hw_done  = sending && tx_done && (cur_q == 2'(g));
      wire can_abt  = abt_req_q[g] && pending[g] && !(sending && cur_q == 2'(g));
      wire sw_queue = wr_txflag && reg_wdata[g] && txe_q[g];
      always_comb begin
        txe_d[g]     = (txe_q[g] && !sw_queue) || hw_done || can_abt;
        abt_ack_d[g] = hw_done ? 1'b0 :
                       can_abt ? 1'b1 :
                       sw_queue ? 1'b0 : abt_ack_q[g];
        abt_req_d[g] = txe_d[g] ? 1'b0 :
                       ((wr_abtreq && reg_wdata[g]) || abt_req_q[g]);
      end
    end
  endgenerate

  // Control flags and selection pointer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txe_q     <= `MBM_TXE_RESET;
      abt_req_q <= 3'h0;
      abt_ack_q <= 3'h0;
      sel_q     <= 3'h0;
      ctrl_q    <= `MBM_CTRL_RESET;
      irq_en_q  <= 5'h00;
    end else begin
      txe_q     <= txe_d;
      abt_req_q <= abt_req_d;
      abt_ack_q <= abt_ack_d;
      if (wr_txsel) begin
        sel_q <= sel_pick & ~(sel_pick - 3'h1);
      end
      if (wr_ctrl) begin
        ctrl_q <= {5'h00, reg_wdata[2:0]};
      end
      if (wr_irqen) begin
        irq_en_q <= reg_wdata[4:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Transmit scheduler: a fresh choice is latched at every arbitration start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_q <= can_mbm_pkg::TX_IDLE;
      cur_q      <= 2'd0;
    end else begin
      unique case (tx_state_q)
        can_mbm_pkg::TX_IDLE: begin
          if (arb_start && best_any) begin
            tx_state_q <= can_mbm_pkg::TX_BUSY;
            cur_q      <= best;
          end
        end
        can_mbm_pkg::TX_BUSY: begin
          // Error and lost arbitration both drop back so the next start re-chooses
          if (tx_done || tx_error || arb_lost) begin
            tx_state_q <= can_mbm_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  assign tx_pending = best_any;
  assign tx_cur_buf = cur_q;
  assign tx_rd_data = tx_rd_data_q;
  // Own frames are not acknowledged unless looped back
  assign rx_ack_ok  = loopback || !sending;

  //////////////////////////////////////////////////////////////////////////////////////
  // Transmit buffer storage; the stamp lands in the buffer that just went out
  always_ff @(posedge mclk) begin
    if (win_wr) begin
      tx_mem[sel_idx][reg_addr[3:0]] <= reg_wdata;
    end
    if (sending && tx_done && ts_en) begin
      tx_mem[cur_q][`MBM_TS_HI_BYTE] <= timer_q[15:8];
      tx_mem[cur_q][`MBM_TS_LO_BYTE] <= timer_q[7:0];
    end
    tx_rd_data_q <= tx_mem[cur_q][tx_rd_idx];
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Receive storage: bytes stream into the background slot while filtering runs
  always_ff @(posedge mclk) begin
    if (rx_wr && !fifo_full && (rx_wr_idx < 4'(`MBM_RX_BYTES))) begin
      rx_mem[bg_slot][rx_wr_idx] <= rx_wr_data;
    end
    if (rx_end && rx_valid && ts_en && !fifo_full) begin
      rx_mem[bg_slot][`MBM_RX_TS_HI] <= timer_q[15:8];
      rx_mem[bg_slot][`MBM_RX_TS_LO] <= timer_q[7:0];
    end
  end

  // Occupancy: a shift and a release in one cycle cancel out, so no event is lost
  always_comb begin
    count_d = count_q;
    if (rx_shift && !rx_release) begin
      count_d = count_q + 3'd1;
    end else if (rx_release && !rx_shift) begin
      count_d = count_q - 3'd1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      head_q  <= 3'd0;
      count_q <= 3'd0;
      ovr_q   <= 1'b0;
    end else begin
      count_q <= count_d;
      if (rx_release) begin
        head_q <= slot_add(head_q, 3'd1);
      end
      // Overrun set wins over a clear in the same cycle
      ovr_q <= rx_ovr || (ovr_q && !(wr_rxflag && reg_wdata[`MBM_RXF_OVR]));
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Stamp timer: free running on bit ticks, wraps silently, held at zero in init
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= 16'h0000;
    end else if (init_mode) begin
      timer_q <= 16'h0000;
    end else if (bit_tick) begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Interrupt lines are plain levels gated by the enable register
  assign tx_irq  = |(txe_q & irq_en_q[2:0]);
  assign rx_irq  = rx_full && irq_en_q[`MBM_IRQ_RX];
  assign err_irq = ovr_q && irq_en_q[`MBM_IRQ_OVR];

  //////////////////////////////////////////////////////////////////////////////////////
  // Read port: data stands in the cycle after the strobe only
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (in_txwin) begin
      rd_mux = sel_ok ? tx_mem[sel_idx][reg_addr[3:0]] : 8'h00;
    end else if (in_rxwin) begin
      rd_mux = (rx_full && reg_addr[3:0] < 4'(`MBM_RX_BYTES))
               ? rx_mem[head_q][reg_addr[3:0]] : 8'h00;
    end else begin
      unique case (reg_addr)
        `MBM_ADDR_TX_FLAG: rd_mux = {5'h00, txe_q};
        `MBM_ADDR_TX_SEL:  rd_mux = {5'h00, sel_q};
        `MBM_ADDR_ABT_REQ: rd_mux = {5'h00, abt_req_q};
        `MBM_ADDR_ABT_ACK: rd_mux = {5'h00, abt_ack_q};
        `MBM_ADDR_RX_FLAG: rd_mux = {6'h00, ovr_q, rx_full};
        `MBM_ADDR_CTRL:    rd_mux = ctrl_q;
        `MBM_ADDR_IRQ_EN:  rd_mux = {3'h0, irq_en_q};
        default:           rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic rx_release_q;

  sequence seq_done_cur;
    sending && tx_done;
  endsequence

  sequence seq_abort_ok(int b);
    abt_req_q[b] && !txe_q[b] && !(sending && cur_q == 2'(b));
  endsequence

  chk_done_sets_empty: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_done_cur |=> txe_q[$past(cur_q)] && !abt_ack_q[$past(cur_q)])
    else $error("Sent buffer not flagged empty with ack clear");
  chk_abort_grant: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_abort_ok(0) |=> txe_q[0] && abt_ack_q[0] && (tx_irq || !irq_en_q[0]))
    else $error("Abort of buffer 0 not granted");
  chk_abort_ack_held: assert property (@(posedge mclk) disable iff (!rst_n)
    abt_ack_q[0] && txe_q[0] && !wr_txflag |=> abt_ack_q[0])
    else $error("Abort ack dropped while buffer still empty");
  chk_lowest_local_priority: assert property (@(posedge mclk) disable iff (!rst_n)
    (!sending && arb_start && best_any && pending == 3'b111 && abt_req_q == 3'b000)
    |=> tx_mem[cur_q][`MBM_LOCAL_PRIORITY_BYTE] <= tx_mem[0][`MBM_LOCAL_PRIORITY_BYTE]
        && tx_mem[cur_q][`MBM_LOCAL_PRIORITY_BYTE] <= tx_mem[1][`MBM_LOCAL_PRIORITY_BYTE]
        && tx_mem[cur_q][`MBM_LOCAL_PRIORITY_BYTE] <= tx_mem[2][`MBM_LOCAL_PRIORITY_BYTE])
    else $error("Chosen buffer does not carry the lowest priority");
  chk_rearbitrate: assert property (@(posedge mclk) disable iff (!rst_n)
    sending && (tx_error || arb_lost) |=> tx_state_q == can_mbm_pkg::TX_IDLE)
    else $error("Scheduler did not release after error or lost arbitration");
  chk_rx_shift: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_shift && !rx_release |=> rx_full && count_q == $past(count_q) + 3'd1)
    else $error("Accepted frame not queued");
  chk_own_dropped: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_end && rx_own && !loopback && !rx_release |=> count_q == $past(count_q))
    else $error("Own frame entered the receive FIFO");
  chk_overrun: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_good && fifo_full |=> ovr_q && count_q == $past(count_q) - (rx_release_q ? 3'd1 : 3'd0))
    else $error("Overrun not flagged or FIFO changed");
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_release_q <= 1'b0;
    end else begin
      rx_release_q <= rx_release;
    end
  end
  chk_timer_init: assert property (@(posedge mclk) disable iff (!rst_n)
    init_mode [*2] |-> timer_q == 16'h0000)
    else $error("Stamp timer not held at zero in init mode");
  chk_fifo_order: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_release |=> head_q == slot_add($past(head_q), 3'd1))
    else $error("Foreground did not advance by one slot");

endmodule : can_message_buffer_manager

// ---- tb/can_bus_node_model.sv ----
// Bus-side partner: protocol engine and remote nodes feeding the buffer manager
`timescale 1ns/100ps
module can_bus_node_model (
  input  wire logic       mclk,
  output logic            bit_tick,
  output logic            arb_start,
  output logic            tx_done,
  output logic            tx_error,
  output logic            arb_lost,
  output logic      [3:0] tx_rd_idx,
  input  wire logic [7:0] tx_rd_data,
  output logic            rx_wr,
  output logic      [3:0] rx_wr_idx,
  output logic      [7:0] rx_wr_data,
  output logic            rx_end,
  output logic            rx_valid,
  output logic            rx_accept,
  output logic            rx_own
);
  logic [1:0] div_q;
  initial begin
    {div_q, bit_tick, arb_start, tx_done, tx_error, arb_lost} = '0;
    {tx_rd_idx, rx_wr, rx_wr_idx, rx_wr_data, rx_end} = '0;
    {rx_valid, rx_accept, rx_own} = '0;
  end
  // Bit clock runs free, one pulse every fourth cycle
  always @(posedge mclk) begin
    div_q <= div_q + 2'h1;
    bit_tick <= (div_q == 2'h3);
  end
  // Start arbitration; returns once the chosen buffer has settled
  task automatic arb();
    @(posedge mclk);
    arb_start <= 1'b1;
    @(posedge mclk);
    arb_start <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : arb
  // End of frame: 0 sent, 1 error, 2 arbitration lost
  task automatic fin(input int k);
    @(posedge mclk);
    {arb_lost, tx_error, tx_done} <= 3'h1 << k;
    @(posedge mclk);
    {arb_lost, tx_error, tx_done} <= 3'h0;
    @(posedge mclk);
    #1;
  endtask : fin
  task automatic fetch(input logic [3:0] i, output logic [7:0] v);
    @(posedge mclk);
    tx_rd_idx <= i;
    @(posedge mclk);
    #1 v = tx_rd_data;
  endtask : fetch
  // Whole frame of 15 bytes, then its end with the qualifiers
  task automatic frame(input logic [7:0] b, input logic v, input logic a, input logic o);
    for (int i = 0; i < 15; i++) begin
      @(posedge mclk);
      rx_wr <= 1'b1;
      rx_wr_idx <= i[3:0];
      rx_wr_data <= b + i[7:0];
    end
    @(posedge mclk);
    rx_wr <= 1'b0;
    rx_end <= 1'b1;
    {rx_valid, rx_accept, rx_own} <= {v, a, o};
    @(posedge mclk);
    rx_end <= 1'b0;
    rx_wr_data <= ~rx_wr_data;  // Released line must not keep its value
    @(posedge mclk);
    #1;
  endtask : frame
endmodule : can_bus_node_model

// ---- tb/tb.sv ----
// Self-checking bench of the message buffer manager
`timescale 1ns/100ps
module tb;
  logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata, tx_rd_data, rx_wr_data, d;
  logic bit_tick, arb_start, tx_done, tx_error, arb_lost, tx_pending;
  logic [3:0] tx_rd_idx, rx_wr_idx;
  logic [1:0] tx_cur_buf;
  logic rx_wr, rx_end, rx_valid, rx_accept, rx_own, rx_ack_ok, tx_irq, rx_irq, err_irq;
  logic [7:0] local_priority [3];
  logic [7:0] b0 [3];
  logic [7:0] rxq [$];
  logic [2:0] pend;
  int err_total = 0, n_tests = 0, seed = 57;
  always #20 mclk = ~mclk;
  can_message_buffer_manager dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .bit_tick, .arb_start, .tx_done, .tx_error, .arb_lost, .tx_rd_idx,
    .tx_pending, .tx_cur_buf, .tx_rd_data, .rx_wr, .rx_wr_idx, .rx_wr_data, .rx_end,
    .rx_valid, .rx_accept, .rx_own, .rx_ack_ok, .tx_irq, .rx_irq, .err_irq);
  can_bus_node_model node (.mclk, .bit_tick, .arb_start, .tx_done, .tx_error, .arb_lost,
    .tx_rd_idx, .tx_rd_data, .rx_wr, .rx_wr_idx, .rx_wr_data, .rx_end, .rx_valid,
    .rx_accept, .rx_own);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask : rc
  // Lowest priority value wins, ties go to the lower index
  function automatic logic [7:0] best(input logic [2:0] m);
    logic [7:0] r;
    logic [8:0] lo;
    r = 8'h03;
    lo = 9'h100;
    for (int i = 0; i < 3; i++) begin
      if (m[i] && {1'b0, local_priority[i]} < lo) begin
        r = i[7:0];
        lo = {1'b0, local_priority[i]};
      end
    end
    return r;
  endfunction : best
  task automatic load(input int b);
    wr(8'h01, 8'h01 << b);
    for (int i = 0; i < 13; i++) begin
      d = $random(seed);
      if (i == 0) b0[b] = d;
      wr(8'h10 + i[7:0], d);
    end
    wr(8'h1d, local_priority[b]);
  endtask : load
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  // A hang of the handshakes ends the run as a failure
  initial begin
    #2000000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rc(8'h00, 8'h07, "empty flags");
    rc(8'h05, 8'h01, "ctrl");
    rc(8'h7f, 8'h00, "unmapped");
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h1f);
    // Buffer 2 gets the top priority so it overtakes after the error
    for (int b = 0; b < 3; b++) begin
      local_priority[b] = (b == 2) ? 8'h00 : ($random(seed) | 8'h01);
      load(b);
    end
    chk("tx_irq", 8'h01, {7'h00, tx_irq});
    wr(8'h00, 8'h03);
    pend = 3'h3;
    chk("pending", 8'h01, {7'h00, tx_pending});
    node.arb();
    chk("ack ok", 8'h00, {7'h00, rx_ack_ok});
    node.fin(2);
    d = $random(seed);
    rxq.push_back(d);
    node.frame(d, 1'b1, 1'b1, 1'b0);
    node.arb();
    chk("cur buf", best(pend), {6'h00, tx_cur_buf});
    node.fin(1);
    wr(8'h00, 8'h04);
    pend = 3'h7;
    repeat (3) begin
      node.arb();
      chk("cur buf", best(pend), {6'h00, tx_cur_buf});
      node.fetch(4'h0, d);
      chk("tx byte", b0[tx_cur_buf], d);
      node.fin(0);
      pend[tx_cur_buf] = 1'b0;
      rc(8'h00, {5'h00, ~pend}, "empty flags");
    end
    rc(8'h03, 8'h00, "abort ack");
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h01);
    chk("pending", 8'h01, {7'h00, tx_pending});
    wr(8'h02, 8'h01);
    repeat (2) @(posedge mclk);
    rc(8'h03, 8'h01, "abort ack");
    rc(8'h00, 8'h07, "empty flags");
    chk("pending", 8'h00, {7'h00, tx_pending});
    // Fill the receive FIFO, then junk, own and one overrun frame
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      rxq.push_back(d);
      node.frame(d, 1'b1, 1'b1, 1'b0);
    end
    chk("rx_irq", 8'h01, {7'h00, rx_irq});
    node.frame(8'h40, 1'b0, 1'b1, 1'b0);
    node.frame(8'h50, 1'b1, 1'b0, 1'b0);
    node.frame(8'h60, 1'b1, 1'b1, 1'b1);
    rc(8'h04, 8'h01, "rx flags");
    node.frame(8'h70, 1'b1, 1'b1, 1'b0);
    rc(8'h04, 8'h03, "rx flags");
    chk("err_irq", 8'h01, {7'h00, err_irq});
    // Drain oldest first; one slot freed lets a new frame in
    for (int k = 0; k < 6; k++) begin
      rc(8'h20, rxq[k], "fg byte0");
      rc(8'h2c, rxq[k] + 8'h0c, "fg byte12");
      wr(8'h04, 8'h01);
      if (k == 0) begin
        d = $random(seed);
        rxq.push_back(d);
        node.frame(d, 1'b1, 1'b1, 1'b0);
      end
    end
    rc(8'h04, 8'h02, "rx flags");
    rc(8'h20, 8'h00, "empty window");
    wr(8'h04, 8'h02);
    chk("rx_irq", 8'h00, {7'h00, rx_irq});
    wr(8'h05, 8'h02);
    chk("ack ok", 8'h01, {7'h00, rx_ack_ok});
    node.frame(8'h80, 1'b1, 1'b1, 1'b1);
    rc(8'h04, 8'h01, "rx flags");
    wr(8'h04, 8'h01);
    wr(8'h05, 8'h05);
    node.frame(8'h90, 1'b1, 1'b1, 1'b0);
    rc(8'h2d, 8'h00, "stamp hi");
    rc(8'h2e, 8'h00, "stamp lo");
    print_verdict();
  end
endmodule : tb
